// ==== hdl/tco_cfg.svh ====
// offsets, field positions, reset values and prescale counts for the timer
`ifndef TCO_CFG_SVH
`define TCO_CFG_SVH

// register offsets on the plain register port
`define TCO_OFS_CONTROL_A    3'h0
`define TCO_OFS_CONTROL_B    3'h1
`define TCO_OFS_COMPARE_A    3'h2
`define TCO_OFS_COMPARE_B    3'h3
`define TCO_OFS_COUNT        3'h4

// control a field positions
`define TCO_CHAN_A_ACT_HI    7
`define TCO_CHAN_A_ACT_LO    6
`define TCO_CHAN_B_ACT_HI    5
`define TCO_CHAN_B_ACT_LO    4
`define TCO_WAVE_LOW_HI      1
`define TCO_WAVE_LOW_LO      0

// control b field positions
`define TCO_WAVE_TOP_BIT     3
`define TCO_CLK_SEL_HI       2
`define TCO_CLK_SEL_LO       0

// reset values and counter limits
`define TCO_CONTROL_RST      8'h00
`define TCO_COMPARE_RST      8'h00
`define TCO_COUNT_RST        8'h00
`define TCO_MAX_TOP          8'hFF
`define TCO_BOTTOM           8'h00

// prescale masks: tick when the low bits of the divider are all ones
`define TCO_DIV8_MASK        10'h007
`define TCO_DIV32_MASK       10'h01F
`define TCO_DIV64_MASK       10'h03F
`define TCO_DIV128_MASK      10'h07F
`define TCO_DIV256_MASK      10'h0FF
`define TCO_DIV1024_MASK     10'h3FF

`endif

// ==== hdl/tco_pkg.sv ====
// types shared by the timer compare output design
`default_nettype none
package tco_pkg;

    // counting sequence chosen by the waveform select bits
    typedef enum logic [1:0] {
        TCO_NORMAL,
        TCO_CTC,
        TCO_FAST,
        TCO_PHASE
    } tco_mode_t;

    // counter state handed to the compare channels
    typedef struct packed {
        logic [7:0] count;
        logic [7:0] top;
        logic       up;
        logic       tick;
    } tco_cnt_t;

endpackage : tco_pkg
`default_nettype wire

// ==== hdl/tco_counter.sv ====
// prescaler and 8-bit up or up/down counter
`include "tco_cfg.svh"
`default_nettype none
module tco_counter (
    // clock and reset
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    // control
    input  wire logic [2:0]        clk_sel_in,
    input  wire tco_pkg::tco_mode_t mode_in,
    input  wire logic [7:0]        top_in,
    input  wire logic              load_in,
    input  wire logic [7:0]        load_value_in,
    // counter state
    output var  tco_pkg::tco_cnt_t cnt_out
);
    logic [9:0] div;
    logic [9:0] next_div;
    logic [7:0] count;
    logic [7:0] next_count;
    logic       up;
    logic       next_up;
    logic       tick;
    logic [9:0] mask;

    // tick enable from the selected division
    always_comb begin
        mask = 10'h000;
        case (clk_sel_in)
            3'h2:    mask = `TCO_DIV8_MASK;
            3'h3:    mask = `TCO_DIV32_MASK;
            3'h4:    mask = `TCO_DIV64_MASK;
            3'h5:    mask = `TCO_DIV128_MASK;
            3'h6:    mask = `TCO_DIV256_MASK;
            3'h7:    mask = `TCO_DIV1024_MASK;
            default: mask = 10'h000;
        endcase
        tick     = (clk_sel_in != 3'h0) && ((div & mask) == mask);
        next_div = div + 10'h001;
    end

    // next count: wrap at top, or turn at top and bottom
    always_comb begin
        next_count = count;
        next_up    = up;
        if (load_in) begin
            next_count = load_value_in;
        end else if (tick) begin
            if (mode_in == tco_pkg::TCO_PHASE) begin
                if (up && count >= top_in) begin
                    next_up    = 1'b0;
                    next_count = (count == `TCO_BOTTOM) ? count : count - 8'h01;
                end else if (!up && count == `TCO_BOTTOM) begin
                    next_up    = 1'b1;
                    next_count = count + 8'h01;
                end else begin
                    next_count = up ? count + 8'h01 : count - 8'h01;
                end
            end else begin
                next_up    = 1'b1;
                next_count = (count == top_in) ? `TCO_BOTTOM : count + 8'h01;
            end
        end
    end

    // register the counter state
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            div   <= 10'h000;
            count <= `TCO_COUNT_RST;
            up    <= 1'b1;
        end else begin
            div   <= next_div;
            count <= next_count;
            up    <= next_up;
        end
    end

    assign cnt_out = '{count: count, top: top_in, up: up, tick: tick};
endmodule : tco_counter
`default_nettype wire

// ==== hdl/tco_channel.sv ====
// output action logic for one compare channel
`include "tco_cfg.svh"
`default_nettype none
module tco_channel #(
    parameter bit CHAN_B = 1'b0
) (
    // clock and reset
    input  wire logic               clk_in,
    input  wire logic               rst_in,
    // control
    input  wire tco_pkg::tco_mode_t mode_in,
    input  wire logic [1:0]         action_in,
    input  wire logic               top_bit_in,
    input  wire logic [7:0]         compare_in,
    input  wire tco_pkg::tco_cnt_t  cnt_in,
    // waveform level
    output logic                    level_out
);
    logic level;
    logic next_level;
    logic match;
    logic at_top;
    logic special;
    logic pwm;

    // action on match, bottom or top per mode
    always_comb begin
        pwm     = (mode_in == tco_pkg::TCO_FAST) || (mode_in == tco_pkg::TCO_PHASE);
        match   = cnt_in.tick && (cnt_in.count == compare_in);
        at_top  = cnt_in.tick && (cnt_in.count == cnt_in.top);
        special = pwm && action_in[1] && (compare_in == cnt_in.top);
        next_level = level;
        case (mode_in)
            tco_pkg::TCO_NORMAL, tco_pkg::TCO_CTC: begin
                if (match) begin
                    case (action_in)
                        2'h1:    next_level = ~level;
                        2'h2:    next_level = 1'b0;
                        2'h3:    next_level = 1'b1;
                        default: next_level = level;
                    endcase
                end
            end
            tco_pkg::TCO_FAST: begin
                if (action_in == 2'h1) begin
                    // channel b code 01 reserved: no action
                    if (!CHAN_B && top_bit_in && match) next_level = ~level;
                end else if (action_in[1]) begin
                    if (match && !special) next_level = action_in[0];
                    else if (at_top) next_level = ~action_in[0];
                end
            end
            tco_pkg::TCO_PHASE: begin
                if (action_in == 2'h1) begin
                    if (!CHAN_B && top_bit_in && match) next_level = ~level;
                end else if (action_in[1]) begin
                    if (special) begin
                        if (at_top) next_level = ~action_in[0];
                    end else if (match) begin
                        next_level = cnt_in.up ? action_in[0] : ~action_in[0];
                    end
                end
            end
            default: next_level = level;
        endcase
    end

    // register the level
    always_ff @(posedge clk_in) begin
        if (rst_in) level <= 1'b0;
        else        level <= next_level;
    end

    assign level_out = level;
endmodule : tco_channel
`default_nettype wire

// ==== hdl/tco_top.sv ====
// timer with two compare outputs, registers and pin override
//
// Operation
// - nonzero channel a code takes pin a, except pwm code 01 with top bit clear
// - non-pwm a: off, toggle, clear, set
// - pwm a code 01: off or toggle
// - fast a: clear/set on match, flip bottom
// - fast, compare at top: skip match
// - phase a: action flips with count direction
// - phase, compare at top: act at top
// - nonzero channel b code takes pin b
// - non-pwm b: off, toggle, clear, set
// - fast b: 01 reserved, 10/11 pwm
// - phase b: 01 reserved, 10/11 pwm
// - control a bits 3 and 2 read zero
// - low bits plus top bit choose mode
`include "tco_cfg.svh"
`default_nettype none
module tco_top (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    // register port
    input  wire logic [2:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_write_in,
    input  wire logic       reg_read_in,
    output logic      [7:0] reg_rdata_out,
    // ordinary port function, index 0 channel a, 1 channel b
    input  wire logic [1:0] port_data_in,
    input  wire logic [1:0] port_dir_in,
    // compare pins
    output logic      [1:0] pin_out,
    output logic      [1:0] pin_oe_n_out
);
    // software visible state
    logic [7:0]         timer2_control_a;
    logic [7:0]         next_timer2_control_a;
    logic [7:0]         timer2_control_b;
    logic [7:0]         next_timer2_control_b;
    logic [1:0][7:0]    compare_value;
    logic [1:0][7:0]    next_compare_value;
    logic [1:0][7:0]    compare_active;
    logic [1:0][7:0]    next_compare_active;
    logic [7:0]         rdata;
    logic [7:0]         next_rdata;
    logic [1:0]         pin;
    logic [1:0]         next_pin;
    logic [1:0]         pin_oe_n;
    logic [1:0]         next_pin_oe_n;

    // decoded control
    logic [1:0]         chan_a_output_action;
    logic [1:0]         chan_b_output_action;
    logic [1:0]         waveform_select_low;
    logic               waveform_select_top_bit;
    logic [2:0]         waveform_select;
    logic [2:0]         clk_sel;
    tco_pkg::tco_mode_t mode;
    logic               top_from_compare;
    logic [7:0]         top;
    logic               count_load;
    logic               update_point;
    tco_pkg::tco_cnt_t  cnt;
    logic [1:0][1:0]    action;
    logic [1:0]         level;
    logic [1:0]         connected;

    // field extraction
    assign chan_a_output_action    = timer2_control_a[`TCO_CHAN_A_ACT_HI:`TCO_CHAN_A_ACT_LO];
    assign chan_b_output_action    = timer2_control_a[`TCO_CHAN_B_ACT_HI:`TCO_CHAN_B_ACT_LO];
    assign waveform_select_low     = timer2_control_a[`TCO_WAVE_LOW_HI:`TCO_WAVE_LOW_LO];
    assign waveform_select_top_bit = timer2_control_b[`TCO_WAVE_TOP_BIT];
    assign clk_sel                 = timer2_control_b[`TCO_CLK_SEL_HI:`TCO_CLK_SEL_LO];
    assign waveform_select         = {waveform_select_top_bit, waveform_select_low};
    assign action[0]               = chan_a_output_action;
    assign action[1]               = chan_b_output_action;

    // mode and top source from the waveform select
    always_comb begin
        mode             = tco_pkg::TCO_NORMAL;
        top_from_compare = 1'b0;
        case (waveform_select)
            3'h1: mode = tco_pkg::TCO_PHASE;
            3'h2: begin
                mode             = tco_pkg::TCO_CTC;
                top_from_compare = 1'b1;
            end
            3'h3: mode = tco_pkg::TCO_FAST;
            3'h5: begin
                mode             = tco_pkg::TCO_PHASE;
                top_from_compare = 1'b1;
            end
            3'h7: begin
                mode             = tco_pkg::TCO_FAST;
                top_from_compare = 1'b1;
            end
            default: mode = tco_pkg::TCO_NORMAL;
        endcase
        top = top_from_compare ? compare_active[0] : `TCO_MAX_TOP;
    end

    // register writes; reserved bits never stored
    always_comb begin
        next_timer2_control_a = timer2_control_a;
        next_timer2_control_b = timer2_control_b;
        next_compare_value    = compare_value;
        count_load            = 1'b0;
        if (reg_write_in) begin
            case (reg_addr_in)
                `TCO_OFS_CONTROL_A: next_timer2_control_a = reg_wdata_in & 8'hF3;
                `TCO_OFS_CONTROL_B: next_timer2_control_b = reg_wdata_in & 8'h0F;
                `TCO_OFS_COMPARE_A: next_compare_value[0] = reg_wdata_in;
                `TCO_OFS_COMPARE_B: next_compare_value[1] = reg_wdata_in;
                `TCO_OFS_COUNT:     count_load            = 1'b1;
                default:            count_load            = 1'b0;
            endcase
        end
    end

    // compare values: immediate outside pwm, buffered to top or bottom in pwm
    always_comb begin
        update_point = 1'b0;
        if (mode == tco_pkg::TCO_PHASE) begin
            update_point = cnt.tick && (cnt.count == cnt.top) && cnt.up;
        end else if (mode == tco_pkg::TCO_FAST) begin
            update_point = cnt.tick && (cnt.count == cnt.top);
        end
        next_compare_active = compare_active;
        for (int i = 0; i < 2; i++) begin
            if (mode == tco_pkg::TCO_NORMAL || mode == tco_pkg::TCO_CTC || update_point) begin
                next_compare_active[i] = compare_value[i];
            end
        end
    end

    // read data for one cycle after the strobe; unmapped reads zero
    always_comb begin
        next_rdata = 8'h00;
        if (reg_read_in) begin
            case (reg_addr_in)
                `TCO_OFS_CONTROL_A: next_rdata = timer2_control_a & 8'hF3;
                `TCO_OFS_CONTROL_B: next_rdata = timer2_control_b;
                `TCO_OFS_COMPARE_A: next_rdata = compare_value[0];
                `TCO_OFS_COMPARE_B: next_rdata = compare_value[1];
                `TCO_OFS_COUNT:     next_rdata = cnt.count;
                default:            next_rdata = 8'h00;
            endcase
        end
    end

    // pin ownership and driver enable
    always_comb begin
        // channel a pwm code 01 with top bit clear stays disconnected
        connected[0] = (chan_a_output_action != 2'h0) &&
                       !((mode == tco_pkg::TCO_FAST || mode == tco_pkg::TCO_PHASE) &&
                         chan_a_output_action == 2'h1 && !waveform_select_top_bit);
        connected[1] = (chan_b_output_action != 2'h0);
        for (int i = 0; i < 2; i++) begin
            next_pin[i]      = connected[i] ? level[i] : port_data_in[i];
            // driver needs the direction bit whoever owns the pin
            next_pin_oe_n[i] = ~port_dir_in[i];
        end
    end

    // register all state and outputs
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            timer2_control_a <= `TCO_CONTROL_RST;
            timer2_control_b <= `TCO_CONTROL_RST;
            compare_value    <= {2{`TCO_COMPARE_RST}};
            compare_active   <= {2{`TCO_COMPARE_RST}};
            rdata            <= 8'h00;
            pin              <= 2'h0;
            pin_oe_n         <= 2'h3;
        end else begin
            timer2_control_a <= next_timer2_control_a;
            timer2_control_b <= next_timer2_control_b;
            compare_value    <= next_compare_value;
            compare_active   <= next_compare_active;
            rdata            <= next_rdata;
            pin              <= next_pin;
            pin_oe_n         <= next_pin_oe_n;
        end
    end

    assign reg_rdata_out = rdata;
    assign pin_out       = pin;
    assign pin_oe_n_out  = pin_oe_n;

    // shared counter
    tco_counter u_counter (
        .clk_in        (clk_in),
        .rst_in        (rst_in),
        .clk_sel_in    (clk_sel),
        .mode_in       (mode),
        .top_in        (top),
        .load_in       (count_load),
        .load_value_in (reg_wdata_in),
        .cnt_out       (cnt)
    );

    // one action unit per channel, same counter, own compare and code
    for (genvar g = 0; g < 2; g++) begin : g_chan
        tco_channel #(
            .CHAN_B (g == 1)
        ) u_chan (
            .clk_in     (clk_in),
            .rst_in     (rst_in),
            .mode_in    (mode),
            .action_in  (action[g]),
            .top_bit_in (waveform_select_top_bit),
            .compare_in (compare_active[g]),
            .cnt_in     (cnt),
            .level_out  (level[g])
        );
    end
endmodule : tco_top
`default_nettype wire

// ==== test/tco_properties.sv ====
// port assertions for the timer compare output block
`default_nettype none
module tco_properties (
    // clock and reset
    input wire logic       clk_in,
    input wire logic       rst_in,
    // register port
    input wire logic [2:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic       reg_write_in,
    input wire logic       reg_read_in,
    input wire logic [7:0] reg_rdata_out,
    // port function and pins
    input wire logic [1:0] port_data_in,
    input wire logic [1:0] port_dir_in,
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe_n_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] ctl_a;
    logic [2:0] clk_sel;
    logic [2:0] quiet;
    default clocking dclk @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    // shadow of control writes and cycles since the last one
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ctl_a   <= 8'h00;
            clk_sel <= 3'h0;
            quiet   <= 3'h0;
        end else begin
            if (reg_write_in && reg_addr_in == 3'h0) begin
                ctl_a <= reg_wdata_in;
            end
            if (reg_write_in && reg_addr_in == 3'h1) begin
                clk_sel <= reg_wdata_in[2:0];
            end
            if (reg_write_in && reg_addr_in < 3'h2) begin
                quiet <= 3'h0;
            end else if (quiet != 3'h7) begin
                quiet <= quiet + 3'h1;
            end
        end
    end

    // control write followed at once by its read
    sequence ctl_write_s;
        reg_write_in && reg_addr_in == 3'h0;
    endsequence
    sequence ctl_read_s;
        reg_read_in && reg_addr_in == 3'h0;
    endsequence

    ctl_readback_a:
        assert property (ctl_write_s ##1 ctl_read_s |=>
            reg_rdata_out == ($past(reg_wdata_in, 2) & 8'hF3))
        else $error("control readback wrong");
    reserved_zero_a:
        assert property ($past(reg_read_in) && $past(reg_addr_in) == 3'h0 |->
            reg_rdata_out[3:2] == 2'b00)
        else $error("reserved bits not zero");
    ctlb_mask_a:
        assert property ($past(reg_read_in) && $past(reg_addr_in) == 3'h1 |->
            reg_rdata_out[7:4] == 4'h0)
        else $error("control b upper bits not zero");
    rdata_idle_a:
        assert property (!$past(reg_read_in) |-> reg_rdata_out == 8'h00)
        else $error("read data outside its cycle");
    drive_enable_a:
        assert property (!$past(rst_in) |-> pin_oe_n_out == ~$past(port_dir_in))
        else $error("driver enable not following direction");
    pass_chan_a:
        assert property (!$past(rst_in) && $past(ctl_a[7:6]) == 2'b00 |->
            pin_out[0] == $past(port_data_in[0]))
        else $error("pin a not ordinary port");
    pin_b_pass_a:
        assert property (!$past(rst_in) && $past(ctl_a[5:4]) == 2'b00 |->
            pin_out[1] == $past(port_data_in[1]))
        else $error("pin b not ordinary port");
    held_stopped_a:
        assert property (quiet > 3'h3 && clk_sel == 3'h0 && ctl_a[7] && ctl_a[5] |->
            $stable(pin_out))
        else $error("pin moved with counter stopped");
endmodule : tco_properties
`default_nettype wire

// ==== test/testbench.sv ====
// self-checking bench for the timer compare output block
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk_in;
    logic       rst_in;
    logic [2:0] reg_addr_in;
    logic [7:0] reg_wdata_in;
    logic       reg_write_in;
    logic       reg_read_in;
    logic [7:0] reg_rdata_out;
    logic [1:0] port_data_in;
    logic [1:0] port_dir_in;
    logic [1:0] pin_out;
    logic [1:0] pin_oe_n_out;
    logic       rd_due;
    logic [7:0] rd_exp;
    logic [7:0] rd_exp_q;
    int         failures;
    int         total_checks;

    tco_top tco_top_inst (
        .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
        .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
        .port_data_in(port_data_in), .port_dir_in(port_dir_in),
        .pin_out(pin_out), .pin_oe_n_out(pin_oe_n_out)
    );

    // 50 MHz clock
    always #10 clk_in = ~clk_in;

    // comparison with count and report
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // read data is due in the cycle after each read strobe
    always @(posedge clk_in) begin
        rd_due   <= reg_read_in;
        rd_exp_q <= rd_exp;
    end
    always @(negedge clk_in) begin
        if (rd_due === 1'b1) begin
            check(reg_rdata_out, rd_exp_q);
        end
    end

    // register port cycles, back to back allowed
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        reg_write_in <= 1'b1;
        reg_read_in  <= 1'b0;
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        @(posedge clk_in);
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        reg_read_in  <= 1'b1;
        reg_write_in <= 1'b0;
        reg_addr_in  <= a;
        rd_exp       <= e;
        @(posedge clk_in);
    endtask : rd
    task automatic idle(input int n);
        reg_read_in  <= 1'b0;
        reg_write_in <= 1'b0;
        repeat (n) @(posedge clk_in);
    endtask : idle

    // compare values written while in normal mode so they apply at once
    task automatic setc(input logic [7:0] a, input logic [7:0] b);
        wr(3'h0, 8'h00);
        wr(3'h2, a);
        wr(3'h3, b);
    endtask : setc

    // run the counter at full rate for n cycles, stop it, compare both pins
    task automatic step(input logic [7:0] ca, input logic top, input logic [7:0] cnt,
                        input int n, input logic [1:0] pd, input logic [1:0] exp);
        port_data_in <= pd;
        port_dir_in  <= ~pd;
        wr(3'h0, ca);
        wr(3'h4, cnt);
        wr(3'h1, {4'h0, top, 3'h1});
        idle(n);
        wr(3'h1, {4'h0, top, 3'h0});
        idle(5);
        @(negedge clk_in);
        check({6'h00, pin_out}, {6'h00, exp});
        check({6'h00, pin_oe_n_out}, {6'h00, pd});
        @(posedge clk_in);
    endtask : step

    // counts and verdict
    task automatic give_verdict();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    // hang guard, well beyond the expected run
    initial begin
        #200000;
        failures++;
        give_verdict();
    end

    // main sequence
    initial begin
        clk_in       = 1'b0;
        rst_in       = 1'b1;
        reg_addr_in  = 3'h0;
        reg_wdata_in = 8'h00;
        reg_write_in = 1'b0;
        reg_read_in  = 1'b0;
        rd_exp       = 8'h00;
        port_data_in = 2'b01;
        port_dir_in  = 2'b10;
        failures     = 0;
        total_checks = 0;
        repeat (19) @(posedge clk_in);
        @(negedge clk_in);
        check({6'h00, pin_oe_n_out}, 8'h03);
        check({6'h00, pin_out}, 8'h00);
        @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        for (int i = 0; i < 8; i++) begin
            rd(3'(i), 8'h00);
        end
        wr(3'h0, 8'hFF);
        rd(3'h0, 8'hF3);
        wr(3'h4, 8'h33);
        rd(3'h4, 8'h33);
        wr(3'h1, 8'hFF);
        rd(3'h1, 8'h0F);
        wr(3'h5, 8'hAA);
        rd(3'h5, 8'h00);
        wr(3'h2, 8'h5A);
        rd(3'h2, 8'h5A);
        wr(3'h3, 8'hA5);
        rd(3'h3, 8'hA5);
        rst_in <= 1'b1;
        idle(20);
        rst_in <= 1'b0;
        @(posedge clk_in);
        // mid-run reset must clear control and compare values
        rd(3'h0, 8'h00);
        rd(3'h2, 8'h00);
        setc(8'h10, 8'h18);
        step(8'h70, 1'b0, 8'h00, 40, 2'b00, 2'b11);
        step(8'hD0, 1'b0, 8'h00, 40, 2'b10, 2'b01);
        step(8'hA0, 1'b0, 8'h00, 40, 2'b11, 2'b00);
        step(8'h00, 1'b0, 8'h00, 8, 2'b10, 2'b10);
        // ctc: top is compare a, so both toggle twice and end unchanged
        setc(8'h10, 8'h08);
        step(8'h52, 1'b0, 8'h00, 40, 2'b01, 2'b00);
        setc(8'h10, 8'h10);
        step(8'hB3, 1'b0, 8'hF0, 20, 2'b10, 2'b01);
        step(8'hB3, 1'b0, 8'h08, 20, 2'b01, 2'b10);
        step(8'h93, 1'b0, 8'hF0, 20, 2'b00, 2'b11);
        step(8'h43, 1'b0, 8'h00, 8, 2'b10, 2'b10);
        step(8'h43, 1'b1, 8'h00, 25, 2'b11, 2'b10);
        setc(8'hFF, 8'h10);
        step(8'h83, 1'b0, 8'hF0, 20, 2'b00, 2'b01);
        setc(8'h10, 8'h10);
        step(8'hB1, 1'b0, 8'h00, 40, 2'b01, 2'b10);
        step(8'hB1, 1'b0, 8'h00, 500, 2'b10, 2'b01);
        setc(8'hFF, 8'hFF);
        step(8'hE1, 1'b0, 8'hF0, 510, 2'b01, 2'b10);
        idle(4);
        give_verdict();
    end
endmodule : testbench

bind tco_top tco_properties tco_properties_inst (
    .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
    .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
    .port_data_in(port_data_in), .port_dir_in(port_dir_in),
    .pin_out(pin_out), .pin_oe_n_out(pin_oe_n_out)
);
`default_nettype wire
